// >>> hfb_pkg.sv
package hfb_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS         = 100;
  localparam int unsigned MAX_BUS_CLOCK_MHZ     = 133;
  localparam int unsigned RESET_RECOVERY_NS     = 1000;
  localparam int unsigned RESET_RECOVERY_CYCLES = (RESET_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0]  RECOVERY_LOAD         = 4'(RESET_RECOVERY_CYCLES);
  localparam logic [3:0]  RECOVERY_DONE         = 4'h0;

  // ---------------------------------------------------------------
  // bus widths and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 8;
  localparam logic [7:0]  READ_FILL  = 8'h00;
  localparam logic [7:0]  REG_RESET  = 8'h00;

  // ---------------------------------------------------------------
  // address regions
  // ---------------------------------------------------------------
  localparam logic [7:0] SYNTH0_FIRST = 8'h00;
  localparam logic [7:0] SYNTH0_LAST  = 8'h1f;
  localparam logic [7:0] SYNTH1_FIRST = 8'h20;
  localparam logic [7:0] SYNTH1_LAST  = 8'h3f;
  localparam logic [7:0] TWIP_FIRST   = 8'h40;
  localparam logic [7:0] TWIP_LAST    = 8'h49;
  localparam logic [7:0] TWIS_FIRST   = 8'h4a;
  localparam logic [7:0] TWIS_LAST    = 8'h53;
  localparam logic [7:0] SPI_FIRST    = 8'h54;
  localparam logic [7:0] SPI_LAST     = 8'h5d;
  localparam logic [7:0] TIMER_FIRST  = 8'h5e;
  localparam logic [7:0] TIMER_LAST   = 8'h6f;
  localparam logic [7:0] NVCS_FIRST   = 8'h70;
  localparam logic [7:0] NVCS_LAST    = 8'h75;
  localparam logic [7:0] IRQSRC_FIRST = 8'h76;
  localparam logic [7:0] IRQSRC_LAST  = 8'h77;
  localparam int unsigned REG_COUNT   = int'(IRQSRC_LAST) + 1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    REGION_NONE   = 9'h001,
    REGION_SYNTH0 = 9'h002,
    REGION_SYNTH1 = 9'h004,
    REGION_TWIP   = 9'h008,
    REGION_TWIS   = 9'h010,
    REGION_SPI    = 9'h020,
    REGION_TIMER  = 9'h040,
    REGION_NVCS   = 9'h080,
    REGION_IRQSRC = 9'h100
  } hfb_region_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_ACK  = 3'h2,
    ST_HOLD = 3'h4
  } hfb_state_e;

  typedef struct packed {
    logic       cyc;
    logic       stb;
    logic       we;
    logic [7:0] adr;
    logic [7:0] wdat;
  } hfb_req_s;

  typedef struct packed {
    logic       en;
    logic [7:0] adr;
    logic [7:0] data;
  } hfb_wr_s;

endpackage

// >>> hfb_region_decode.sv
`timescale 1ns/100ps
module hfb_region_decode import hfb_pkg::*; (
  input  wire logic        synth1_present_in,
  input  wire logic [7:0]  address_in,
  output hfb_region_e      region_out,
  output logic             valid_out
);

  // ---------------------------------------------------------------
  // region lookup
  // ---------------------------------------------------------------
  function automatic hfb_region_e region_of(input logic [7:0] a, input logic synth1_on);
    hfb_region_e r;
    r = REGION_NONE;
    if (a <= SYNTH0_LAST) begin
      r = REGION_SYNTH0;
    end else if (a >= SYNTH1_FIRST && a <= SYNTH1_LAST) begin
      r = synth1_on ? REGION_SYNTH1 : REGION_NONE;
    end else if (a >= TWIP_FIRST && a <= TWIP_LAST) begin
      r = REGION_TWIP;
    end else if (a >= TWIS_FIRST && a <= TWIS_LAST) begin
      r = REGION_TWIS;
    end else if (a >= SPI_FIRST && a <= SPI_LAST) begin
      r = REGION_SPI;
    end else if (a >= TIMER_FIRST && a <= TIMER_LAST) begin
      r = REGION_TIMER;
    end else if (a >= NVCS_FIRST && a <= NVCS_LAST) begin
      r = REGION_NVCS;
    end else if (a >= IRQSRC_FIRST && a <= IRQSRC_LAST) begin
      r = REGION_IRQSRC;
    end
    return r;
  endfunction

  always_comb begin
    region_out = region_of(address_in, synth1_present_in); // R8 R9
    valid_out  = (region_out != REGION_NONE);
  end

endmodule // hfb_region_decode

// >>> hfb_reg_store.sv
`timescale 1ns/100ps
module hfb_reg_store import hfb_pkg::*; (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire hfb_wr_s     write_in,
  input  wire logic [7:0]  read_address_in,
  output logic [7:0]       read_data_out
);

  logic [7:0] mem [REG_COUNT];

  // ---------------------------------------------------------------
  // byte registers, cleared only at power-on reset
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_byte
      always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          mem[i] <= REG_RESET;
        end else if (write_in.en && write_in.adr == 8'(i)) begin
          mem[i] <= write_in.data; // R7
        end
      end
    end
  endgenerate

  always_comb begin
    if (read_address_in <= IRQSRC_LAST) begin
      read_data_out = mem[read_address_in[6:0]];
    end else begin
      read_data_out = READ_FILL;
    end
  end

endmodule // hfb_reg_store

// >>> hfb_wishbone_port.sv
// Operation
// R1 - all logic registers on rising edge of one bus clock, up to 133 MHz
// R2 - bus reset is synchronous, aborts transfers, clears only interface logic
// R3 - master waits 1 us after bus reset release before next transfer
// R4 - bus reset may be held any length; port recovers on release
// R5 - cycle-valid and strobe both high are answered with acknowledge
// R6 - write-enable low reads, high writes; held steady for the cycle
// R7 - 8-bit address picks one register; one byte moves per cycle
// R8 - 0x00-0x1F first synth, 0x20-0x3F second synth when present
// R9 - fixed byte regions for serial, timer, store and interrupt source
// R10 - undefined addresses still get acknowledge; their read data is undefined
// R11 - master keeps to defined address regions
// R12 - classic single cycles only; no tags, no byte selects
// R13 - master drives address, data, write-enable, cycle-valid, strobe together
// R14 - write takes at least three edges: setup, decode, completion
// R15 - port may add wait states; master holds outputs until acknowledge
// R16 - write data captured into register on the acknowledged edge
// R17 - master drops strobe on completion; port drops acknowledge in reply
// R18 - read takes at least three edges with write-enable low
// R19 - read data valid while acknowledge high; master captures it then
// R20 - master drops cycle-valid and strobe at once on acknowledge
// R21 - user arbiter passes only winning master's signals to the port
// R22 - bus clock at least 7.5x two-wire rate, twice serial clock
// R23 - one acknowledge per strobe; no repeat until strobe drops and rises
`timescale 1ns/100ps
module hfb_wishbone_port import hfb_pkg::*; #(
  parameter logic SECOND_SYNTH_PRESENT = 1'b1
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        bus_reset_in,
  input  wire logic        cycle_valid_in,
  input  wire logic        strobe_in,
  input  wire logic        write_enable_in,
  input  wire logic [7:0]  register_address_in,
  input  wire logic [7:0]  write_data_in,
  output logic [7:0]       read_data_out,
  output logic             transfer_ack_out,
  output logic [8:0]       region_select_out,
  output logic             bus_ready_out
);

  // ---------------------------------------------------------------
  // request bundle
  // ---------------------------------------------------------------
  hfb_req_s    req;
  hfb_wr_s     wr;
  hfb_state_e  state;
  hfb_state_e  next_state;
  hfb_region_e region;
  logic        region_valid;
  logic        request;
  logic [7:0]  store_rdata;
  logic [7:0]  read_data;
  hfb_region_e region_sel;
  logic [3:0]  recovery;

  always_comb begin
    req.cyc  = cycle_valid_in;
    req.stb  = strobe_in;
    req.we   = write_enable_in; // R6 R12
    req.adr  = register_address_in;
    req.wdat = write_data_in;
    request  = req.cyc && req.stb; // R5
  end

  // ---------------------------------------------------------------
  // address decode and register store
  // ---------------------------------------------------------------
  hfb_region_decode u_decode (
    .synth1_present_in (SECOND_SYNTH_PRESENT),
    .address_in        (req.adr),
    .region_out        (region),
    .valid_out         (region_valid)
  );

  hfb_reg_store u_store (
    .sys_clk_in      (sys_clk_in),
    .rst_n_in        (rst_n_in),
    .write_in        (wr),
    .read_address_in (req.adr),
    .read_data_out   (store_rdata)
  );

  // ---------------------------------------------------------------
  // transfer state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (request) begin
          next_state = ST_ACK; // R5 R14 R18
        end
      end
      ST_ACK: begin
        if (request) begin
          next_state = ST_HOLD; // R23
        end else begin
          next_state = ST_IDLE; // R17
        end
      end
      ST_HOLD: begin
        if (!req.stb) begin
          next_state = ST_IDLE; // R23
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin // R1
    if (!rst_n_in) begin
      state <= ST_IDLE;
    end else if (bus_reset_in) begin
      state <= ST_IDLE; // R2 R4
    end else begin
      state <= next_state;
    end
  end

  assign transfer_ack_out = (state == ST_ACK); // R5 R10 R15

  hold_entry_a: assert property ( // R23
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (transfer_ack_out && request) |=> state == ST_HOLD
  ) else $error("strobe held after acknowledge not parked");

  hold_exit_a: assert property ( // R23
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == ST_HOLD && !req.stb) |=> state == ST_IDLE
  ) else $error("dropped strobe did not free the port");

  idle_quiet_a: assert property ( // R5
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (state == ST_IDLE && !request) |=> !transfer_ack_out
  ) else $error("acknowledge without a request");

  // ---------------------------------------------------------------
  // write path
  // ---------------------------------------------------------------
  always_comb begin
    wr.en   = (state == ST_ACK) && request && req.we && region_valid && !bus_reset_in; // R16 R10 R2
    wr.adr  = req.adr; // R7
    wr.data = req.wdat;
  end

  write_guard_a: assert property ( // R10 R6 R2
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (!region_valid || !req.we || bus_reset_in) |-> !wr.en
  ) else $error("store written by a blocked access");

  write_edge_a: assert property ( // R14
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.en |-> $past(state == ST_IDLE && request)
  ) else $error("store written without a decode edge");

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      read_data <= READ_FILL;
    end else if (bus_reset_in) begin
      read_data <= READ_FILL; // R2
    end else if (state == ST_IDLE && request && !req.we) begin
      read_data <= region_valid ? store_rdata : READ_FILL; // R19 R10
    end
  end

  assign read_data_out = read_data;

  read_load_a: assert property ( // R19
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (state == ST_IDLE && request && !req.we && region_valid) |=> read_data_out == $past(store_rdata)
  ) else $error("read byte not loaded");

  undef_fill_a: assert property ( // R10
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (state == ST_IDLE && request && !req.we && !region_valid) |=> read_data_out == READ_FILL
  ) else $error("undefined read not filled");

  read_hold_a: assert property ( // R19
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    !(state == ST_IDLE && request && !req.we) |=> $stable(read_data_out)
  ) else $error("read byte changed without a read");

  // ---------------------------------------------------------------
  // region of the last access
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      region_sel <= REGION_NONE;
    end else if (bus_reset_in) begin
      region_sel <= REGION_NONE;
    end else if (state == ST_IDLE && request) begin
      region_sel <= region; // R8 R9
    end
  end

  assign region_select_out = region_sel;

  region_load_a: assert property ( // R8 R9
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (state == ST_IDLE && request) |=> region_select_out == $past(region)
  ) else $error("region of access not recorded");

  region_hold_a: assert property ( // R9
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    !(state == ST_IDLE && request) |=> $stable(region_select_out)
  ) else $error("region changed without an access");

  synth1_map_a: assert property ( // R8
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (req.adr >= SYNTH1_FIRST && req.adr <= SYNTH1_LAST) |-> ((region == REGION_SYNTH1) == SECOND_SYNTH_PRESENT)
  ) else $error("second synth region decoded wrongly");

  // ---------------------------------------------------------------
  // recovery window after bus reset
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      recovery <= RECOVERY_DONE;
    end else if (bus_reset_in) begin
      recovery <= RECOVERY_LOAD; // R3 R4
    end else if (recovery != RECOVERY_DONE) begin
      recovery <= recovery - 4'h1;
    end
  end

  assign bus_ready_out = !bus_reset_in && (recovery == RECOVERY_DONE);

  reset_busy_a: assert property ( // R4
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_reset_in |-> !bus_ready_out
  ) else $error("ready shown during bus reset");

  reset_clear_a: assert property ( // R2
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> read_data_out == READ_FILL && region_select_out == REGION_NONE
  ) else $error("bus reset left interface outputs set");

  recovery_step_a: assert property ( // R3
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (recovery != RECOVERY_DONE && !bus_reset_in) |=> recovery == $past(recovery) - 4'h1
  ) else $error("recovery count did not step");

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ack_on_strobe_a: assert property ( // R5
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (state == ST_IDLE && request) |=> transfer_ack_out
  ) else $error("strobe not acknowledged");

  ack_has_cause_a: assert property ( // R14
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    transfer_ack_out |-> $past(request) && !$past(bus_reset_in)
  ) else $error("acknowledge without prior strobe");

  single_ack_a: assert property ( // R23
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    transfer_ack_out |=> !transfer_ack_out
  ) else $error("acknowledge repeated");

  hold_no_ack_a: assert property ( // R23
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (transfer_ack_out && request) ##1 req.stb [*2] |-> !transfer_ack_out
  ) else $error("acknowledge while strobe held");

  reset_clears_ack_a: assert property ( // R2
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    bus_reset_in |=> !transfer_ack_out && state == ST_IDLE
  ) else $error("bus reset left transfer active");

  reset_keeps_regs_a: assert property ( // R2
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (bus_reset_in && $stable(req.adr)) |=> store_rdata == $past(store_rdata) || $changed(req.adr)
  ) else $error("bus reset changed register contents");

  undefined_ack_a: assert property ( // R10
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (state == ST_IDLE && request && !region_valid) |=> transfer_ack_out ##1 !transfer_ack_out
  ) else $error("undefined address not acknowledged");

  write_on_ack_a: assert property ( // R16
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.en |-> transfer_ack_out && req.we && $past(request)
  ) else $error("write outside acknowledged edge");

  write_lands_a: assert property ( // R16
    @(posedge sys_clk_in) disable iff (!rst_n_in || bus_reset_in)
    (wr.en ##2 (request && !req.we && req.adr == $past(req.adr, 2) && state == ST_IDLE))
      |=> read_data_out == $past(req.wdat, 3)
  ) else $error("written byte not read back");

  read_data_valid_a: assert property ( // R19
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    (transfer_ack_out && !req.we && $past(region_valid)) |-> read_data_out == $past(store_rdata)
  ) else $error("read data wrong during acknowledge");

  recovery_window_a: assert property ( // R3
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(bus_reset_in) |-> !bus_ready_out [*8] ##1 !bus_ready_out [*2] ##1 bus_ready_out
  ) else $error("recovery window length wrong");

endmodule // hfb_wishbone_port

// >>> hfb_master_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// bus master model
// ---------------------------------------------------------------
module hfb_master_model (
  input  wire logic        sys_clk_in,
  input  wire logic        ack_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic        ready_in,
  output logic             cyc_out,
  output logic             stb_out,
  output logic             we_out,
  output logic [7:0]       adr_out,
  output logic [7:0]       wdat_out
);
  initial begin
    cyc_out  = 1'b0;
    stb_out  = 1'b0;
    we_out   = 1'b0;
    adr_out  = 8'h00;
    wdat_out = 8'h00;
  end

  // raise one request on a falling edge, all qualifiers together
  task automatic start(input logic we, input logic [7:0] adr, input logic [7:0] dat, input bit wait_rdy);
    int n;
    n = 0;
    while (wait_rdy && ready_in !== 1'b1 && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    @(negedge sys_clk_in);
    we_out   = we;
    adr_out  = adr;
    wdat_out = dat;
    cyc_out  = 1'b1;
    stb_out  = 1'b1;
  endtask

  // release the bus; released lines show the inverse of their last value
  task automatic drop();
    @(negedge sys_clk_in);
    cyc_out  = 1'b0;
    stb_out  = 1'b0;
    we_out   = ~we_out;
    adr_out  = ~adr_out;
    wdat_out = ~wdat_out;
  endtask

  // one whole transfer; extra holds the strobe on after the acknowledge
  task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] dat, input int extra,
                      output logic [7:0] rdat, output int lat, output int acks);
    start(we, adr, dat, 1'b1);
    lat  = 0;
    acks = 0;
    rdat = 8'hxx;
    do begin
      @(posedge sys_clk_in);
      lat++;
    end while (ack_in !== 1'b1 && lat < 16);
    if (ack_in === 1'b1) begin
      acks = 1;
      rdat = rdata_in;
    end
    repeat (extra) begin
      @(posedge sys_clk_in);
      if (ack_in === 1'b1) acks++;
    end
    drop();
  endtask
endmodule // hfb_master_model

// >>> test_hard_block_wishbone_slave_port.sv
`timescale 1ns/100ps
`define CHECK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
  $display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module test_hard_block_wishbone_slave_port;
  import hfb_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        bus_reset = 1'b0;
  logic        cyc, stb, we, ack, ready;
  logic [7:0]  adr, wdat, rdata;
  logic [8:0]  region;
  int          fails = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  logic [7:0]  adrs [16] = '{8'h00, 8'h1f, 8'h20, 8'h3f, 8'h40, 8'h49, 8'h4a, 8'h53,
                             8'h54, 8'h5d, 8'h5e, 8'h6f, 8'h70, 8'h75, 8'h76, 8'h77};

  always #50 sys_clk = ~sys_clk;

  hfb_wishbone_port DUT (
    .sys_clk_in          (sys_clk),
    .rst_n_in            (rst_n),
    .bus_reset_in        (bus_reset),
    .cycle_valid_in      (cyc),
    .strobe_in           (stb),
    .write_enable_in     (we),
    .register_address_in (adr),
    .write_data_in       (wdat),
    .read_data_out       (rdata),
    .transfer_ack_out    (ack),
    .region_select_out   (region),
    .bus_ready_out       (ready)
  );

  hfb_master_model u_master (
    .sys_clk_in (sys_clk),
    .ack_in     (ack),
    .rdata_in   (rdata),
    .ready_in   (ready),
    .cyc_out    (cyc),
    .stb_out    (stb),
    .we_out     (we),
    .adr_out    (adr),
    .wdat_out   (wdat)
  );

  // ---------------------------------------------------------------
  // verdict and hang guard
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_idle();
    @(negedge sys_clk);
    `CHECK("ack idle", 1'b0, ack)
    `CHECK("region idle", 9'h001, region)
    `CHECK("ready idle", 1'b1, ready)
  endtask

  // every region edge written, then all read back to catch aliasing
  task automatic test_regions();
    logic [7:0] rd;
    int lat, acks;
    for (int i = 0; i < 16; i++) begin
      u_master.xfer(1'b1, adrs[i], adrs[i] ^ 8'ha5, 0, rd, lat, acks);
      `CHECK("write latency", 2, lat)
      `CHECK("write acks", 1, acks)
    end
    for (int i = 0; i < 16; i++) begin
      u_master.xfer(1'b0, adrs[i], 8'h00, 0, rd, lat, acks);
      `CHECK("read latency", 2, lat)
      `CHECK("read data", adrs[i] ^ 8'ha5, rd)
      `CHECK("region", 9'h001 << (i / 2 + 1), region)
    end
  endtask

  task automatic test_undefined();
    logic [7:0] rd;
    int lat, acks;
    u_master.xfer(1'b1, 8'h80, 8'h3c, 0, rd, lat, acks);
    `CHECK("undef write ack", 1, acks)
    u_master.xfer(1'b0, 8'hff, 8'h00, 0, rd, lat, acks);
    `CHECK("undef read ack", 1, acks)
    `CHECK("undef region", 9'h001, region)
    u_master.xfer(1'b0, 8'h00, 8'h00, 0, rd, lat, acks);
    `CHECK("no alias", 8'h00 ^ 8'ha5, rd)
  endtask

  // strobe held on after the acknowledge, then a request straight after
  task automatic test_held_strobe();
    logic [7:0] rd;
    int lat, acks;
    u_master.xfer(1'b0, 8'h40, 8'h00, 5, rd, lat, acks);
    `CHECK("held acks", 1, acks)
    u_master.xfer(1'b1, 8'h41, 8'h11, 0, rd, lat, acks);
    `CHECK("next latency", 2, lat)
    u_master.xfer(1'b0, 8'h41, 8'h00, 0, rd, lat, acks);
    `CHECK("next data", 8'h11, rd)
  endtask

  // bus reset over a pending write; map keeps its contents
  task automatic test_bus_reset();
    logic [7:0] rd;
    int lat, acks, n;
    @(negedge sys_clk);
    bus_reset = 1'b1;
    u_master.start(1'b1, 8'h40, 8'hc3, 1'b0);
    repeat (4) begin
      @(negedge sys_clk);
      `CHECK("ack in reset", 1'b0, ack)
      `CHECK("ready in reset", 1'b0, ready)
    end
    u_master.drop();
    bus_reset = 1'b0;
    n = 0;
    while (ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    `CHECK("recovery window", RESET_RECOVERY_CYCLES, n)
    u_master.xfer(1'b0, 8'h40, 8'h00, 0, rd, lat, acks);
    `CHECK("kept data", 8'h40 ^ 8'ha5, rd)
    `CHECK("recovered latency", 2, lat)
  endtask

  initial begin
    repeat (5) @(negedge sys_clk);
    rst_n = 1'b1;
    test_idle();
    test_regions();
    test_undefined();
    test_held_strobe();
    test_bus_reset();
    finish_test();
  end
endmodule // test_hard_block_wishbone_slave_port
